// *** inc/tmr_pkg.sv ***
package tmr_pkg;

  localparam int unsigned CNT_W        = 16;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_ONE      = 16'h0001;

  // operation mode field {op_mode_sel_high, op_mode_sel_low}
  typedef enum logic [1:0] {
    MODE_STOP        = 2'b00,
    MODE_EDGE_CLEAR  = 2'b01,
    MODE_FREE_RUN    = 2'b10,
    MODE_MATCH_CLEAR = 2'b11
  } tmr_mode_e;

  // count clock select
  localparam logic [1:0] PSEL_DIV1     = 2'h0;
  localparam logic [1:0] PSEL_DIV4     = 2'h1;
  localparam logic [1:0] PSEL_DIV16    = 2'h2;
  localparam logic [1:0] PSEL_EXT      = 2'h3;
  localparam int unsigned PRE_W        = 8;
  localparam logic [7:0] PRE_LAST_DIV1  = 8'h00;
  localparam logic [7:0] PRE_LAST_DIV4  = 8'h03;
  localparam logic [7:0] PRE_LAST_DIV16 = 8'h0f;

  // valid edge select
  localparam logic [1:0] EDGE_FALL     = 2'h0;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_NONE     = 2'h2;
  localparam logic [1:0] EDGE_BOTH     = 2'h3;

  // capture control register fields
  localparam int unsigned CCR_W        = 3;
  localparam int unsigned CCR_FIRST_CAP  = 0;
  localparam int unsigned CCR_REV_PHASE  = 1;
  localparam int unsigned CCR_SECOND_CAP = 2;
  localparam logic [2:0] CCR_RESET     = 3'h0;

endpackage : tmr_pkg

// *** rtl/tmr_presc.sv ***
`timescale 1ns/100ps
module tmr_presc
  import tmr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] psel,
  output logic            tick
);

  logic [PRE_W-1:0] cnt_q, cnt_d;
  logic [PRE_W-1:0] last;
  logic             tick_d;

  always_comb begin
    unique case (psel)
      PSEL_DIV1:  last = PRE_LAST_DIV1;
      PSEL_DIV4:  last = PRE_LAST_DIV4;
      PSEL_DIV16: last = PRE_LAST_DIV16;
      PSEL_EXT:   last = PRE_LAST_DIV1;
    endcase
    tick_d = 1'b0;
    cnt_d  = '0;
    if (run && psel != PSEL_EXT) begin
      if (cnt_q == last) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule : tmr_presc

// *** rtl/tmr_edge.sv ***
`timescale 1ns/100ps
module tmr_edge
  import tmr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       sample,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            edge_valid,
  output logic            edge_rev
);

  logic smp_q, smp_d;
  logic lvl_q, lvl_d;
  logic ran_q, ran_d;
  logic val_d, rev_d;
  logic rise, fall;

  always_comb begin
    smp_d = smp_q;
    lvl_d = lvl_q;
    ran_d = ran_q | run;
    rise  = 1'b0;
    fall  = 1'b0;
    if (run) begin
      if (sample) begin
        smp_d = pin;
        // level accepted only after two equal samples in a row
        if (smp_q == pin) begin
          lvl_d = pin;
          rise  = pin & ~lvl_q;
          fall  = ~pin & lvl_q;
        end
      end
    end else if (ran_q) begin
      // after a first run, track the pin silently so a restart sees no edge
      smp_d = pin;
      lvl_d = pin;
    end
    // before the first run the level stays low: a high pin reads as rise
    val_d = run & ((rise & (edge_sel == EDGE_RISE ||
                            edge_sel == EDGE_BOTH)) |
                   (fall & (edge_sel == EDGE_FALL ||
                            edge_sel == EDGE_BOTH)));
    rev_d = run & ((fall & edge_sel == EDGE_RISE) |
                   (rise & edge_sel == EDGE_FALL));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      smp_q      <= 1'b0;
      lvl_q      <= 1'b0;
      ran_q      <= 1'b0;
      edge_valid <= 1'b0;
      edge_rev   <= 1'b0;
    end else begin
      smp_q      <= smp_d;
      lvl_q      <= lvl_d;
      ran_q      <= ran_d;
      edge_valid <= val_d;
      edge_rev   <= rev_d;
    end
  end

  a_edge_needs_run: assert property (@(posedge clk_sys) disable iff (rst)
    edge_valid |-> $past(run) && $past(sample))
    else $error("edge reported while stopped or without a sample");

  a_edge_two_samples: assert property (@(posedge clk_sys) disable iff (rst)
    edge_valid |-> $past(smp_q) == $past(pin))
    else $error("edge accepted after a single sample");

endmodule : tmr_edge

// *** rtl/tmr_timer16.sv ***
`timescale 1ns/100ps
module tmr_timer16
  import tmr_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             op_mode_sel_high,
  input  wire logic             op_mode_sel_low,
  input  wire logic [1:0]       prescaler_select,
  input  wire logic [CCR_W-1:0] capture_control_reg,
  input  wire logic [1:0]       edge_sel_first,
  input  wire logic [1:0]       edge_sel_second,
  input  wire logic             edge_input_first,
  input  wire logic             edge_input_second,
  input  wire logic             cmp_first_wr,
  input  wire logic [15:0]      cmp_first_wdata,
  input  wire logic             cmp_second_wr,
  input  wire logic [15:0]      cmp_second_wdata,
  input  wire logic             overflow_clr,
  input  wire logic             one_shot_en,
  input  wire logic             one_shot_trig,
  output logic [15:0]           main_count,
  output logic [15:0]           compare_capture_first,
  output logic [15:0]           compare_capture_second,
  output logic                  overflow_flag,
  output logic                  irq_match_first,
  output logic                  irq_match_second,
  output logic                  one_shot_out
);

  ////////////////////////////////////////////////////////////////////////////
  // mode, count clock and edge inputs

  tmr_mode_e mode;
  logic      run;
  logic      pre_tick;
  logic      ext_clk;
  logic      tick;
  logic      first_sample;
  logic      first_edge, first_rev;
  logic      second_edge;
  logic      cap_first_en, cap_second_en, rev_sel;

  assign mode = tmr_mode_e'({op_mode_sel_high, op_mode_sel_low});
  assign run  = (mode != MODE_STOP);
  assign ext_clk = (prescaler_select == PSEL_EXT);
  assign tick = ext_clk ? first_edge : pre_tick;
  assign first_sample = ext_clk ? 1'b1 : pre_tick;
  assign cap_first_en  = capture_control_reg[CCR_FIRST_CAP];
  assign rev_sel       = capture_control_reg[CCR_REV_PHASE];
  assign cap_second_en = capture_control_reg[CCR_SECOND_CAP];

  tmr_presc u_presc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (run),
    .psel    (prescaler_select),
    .tick    (pre_tick)
  );

  tmr_edge u_edge_first (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run        (run),
    .sample     (first_sample),
    .pin        (edge_input_first),
    .edge_sel   (edge_sel_first),
    .edge_valid (first_edge),
    .edge_rev   (first_rev)
  );

  tmr_edge u_edge_second (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run        (run),
    .sample     (pre_tick),
    .pin        (edge_input_second),
    .edge_sel   (edge_sel_second),
    .edge_valid (second_edge),
    .edge_rev   ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // counter, overflow and one-shot

  logic [15:0] cnt_d;
  logic        ovf_d, wrap_q, wrap_d, os_d;
  logic        match_first, match_second;
  logic        wrap_ev;

  always_comb begin
    cnt_d   = main_count;
    wrap_d  = wrap_q;
    wrap_ev = 1'b0;
    os_d    = one_shot_out;
    match_first  = tick && (main_count == compare_capture_first);
    match_second = tick && (main_count == compare_capture_second);
    if (!run) begin
      cnt_d  = CNT_ZERO;
      wrap_d = 1'b0;
      os_d   = 1'b0;
    end else begin
      if (tick) begin
        wrap_d = 1'b0;
        if (mode == MODE_MATCH_CLEAR && !cap_first_en && match_first) begin
          cnt_d   = CNT_ZERO;
          // clear from FFFFH on a match counts as an overflow
          wrap_ev = (main_count == CNT_MAX);
        end else begin
          cnt_d   = main_count + CNT_ONE;
          wrap_ev = (main_count == CNT_MAX);
        end
        wrap_d = wrap_ev;
      end
      if (mode == MODE_EDGE_CLEAR && first_edge && !ext_clk) begin
        cnt_d = CNT_ZERO;
      end
      if (mode == MODE_MATCH_CLEAR || !one_shot_en) begin
        os_d = 1'b0;
      end else if (match_first) begin
        os_d = 1'b0;
      end else if (match_second &&
                   (one_shot_trig || mode == MODE_EDGE_CLEAR)) begin
        os_d = 1'b1;
      end
    end
    // set wins over clear; a clear while the count still sits at 0000H
    // after a wrap is overridden
    ovf_d = (overflow_flag & ~overflow_clr) | wrap_ev | wrap_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      main_count    <= CNT_ZERO;
      overflow_flag <= 1'b0;
      wrap_q        <= 1'b0;
      one_shot_out  <= 1'b0;
    end else begin
      main_count    <= cnt_d;
      overflow_flag <= ovf_d;
      wrap_q        <= wrap_d;
      one_shot_out  <= os_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare/capture registers and interrupts

  logic [15:0] ccf_d, ccs_d;
  logic        pend_first_q, pend_first_d;
  logic        pend_second_q, pend_second_d;
  logic        irq_first_d, irq_second_d;

  always_comb begin
    ccf_d         = compare_capture_first;
    ccs_d         = compare_capture_second;
    pend_first_d  = pend_first_q;
    pend_second_d = pend_second_q;
    irq_first_d   = 1'b0;
    irq_second_d  = 1'b0;
    if (cmp_first_wr) begin
      ccf_d = cmp_first_wdata;
    end
    if (cmp_second_wr) begin
      ccs_d = cmp_second_wdata;
    end
    if (!run) begin
      pend_first_d  = 1'b0;
      pend_second_d = 1'b0;
    end else begin
      // pending interrupts fire on the next count clock
      if (tick) begin
        irq_first_d   = pend_first_q;
        irq_second_d  = pend_second_q;
        pend_first_d  = 1'b0;
        pend_second_d = 1'b0;
      end
      if (cap_first_en) begin
        if (rev_sel) begin
          if (first_rev) begin
            ccf_d = main_count;
          end
          if (second_edge) begin
            pend_first_d = 1'b1;
          end
        end else if (second_edge) begin
          ccf_d        = main_count;
          pend_first_d = 1'b1;
        end
      end else if (match_first) begin
        irq_first_d = 1'b1;
      end
      if (cap_second_en) begin
        if (first_edge) begin
          ccs_d         = main_count;
          pend_second_d = 1'b1;
        end
      end else if (match_second) begin
        irq_second_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compare_capture_first  <= CNT_ZERO;
      compare_capture_second <= CNT_ZERO;
      pend_first_q           <= 1'b0;
      pend_second_q          <= 1'b0;
      irq_match_first        <= 1'b0;
      irq_match_second       <= 1'b0;
    end else begin
      compare_capture_first  <= ccf_d;
      compare_capture_second <= ccs_d;
      pend_first_q           <= pend_first_d;
      pend_second_q          <= pend_second_d;
      irq_match_first        <= irq_first_d;
      irq_match_second       <= irq_second_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_ovf_free_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    run && tick && mode == MODE_FREE_RUN && main_count == CNT_MAX
    |=> overflow_flag && main_count == CNT_ZERO)
    else $error("free-run wrap did not set overflow");

  a_ovf_match_clear: assert property (@(posedge clk_sys) disable iff (rst)
    run && tick && mode == MODE_MATCH_CLEAR && !cap_first_en &&
    compare_capture_first == CNT_MAX && main_count == CNT_MAX
    |=> overflow_flag ##1 overflow_flag)
    else $error("match clear from FFFFH did not set overflow");

  a_ovf_clear_void: assert property (@(posedge clk_sys) disable iff (rst)
    wrap_q && overflow_clr && run |=> overflow_flag)
    else $error("overflow clear took effect before count 0001H");

  a_ovf_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    overflow_flag && !overflow_clr |=> overflow_flag)
    else $error("overflow flag dropped without a clear");

  a_oneshot_mode: assert property (@(posedge clk_sys) disable iff (rst)
    mode == MODE_MATCH_CLEAR |=> !one_shot_out)
    else $error("one-shot output active in match-clear mode");

  a_cap_irq_delay: assert property (@(posedge clk_sys) disable iff (rst)
    run && cap_second_en && first_edge && !tick
    |=> compare_capture_second == $past(main_count) &&
        !irq_match_second)
    else $error("capture interrupt not deferred to next count clock");

  a_rev_no_irq: assert property (@(posedge clk_sys) disable iff (rst)
    run && cap_first_en && rev_sel && !pend_first_q && !second_edge
    |=> !irq_match_first)
    else $error("reverse-phase capture raised the first interrupt");

  a_rev_ext_irq: assert property (@(posedge clk_sys) disable iff (rst)
    run && cap_first_en && rev_sel && second_edge && !first_rev
    |=> $stable(compare_capture_first) && pend_first_q)
    else $error("second-input edge captured in reverse-phase mode");

  a_stop_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !run |=> main_count == CNT_ZERO && !irq_match_first &&
             !irq_match_second && !one_shot_out)
    else $error("timer active while stopped");

endmodule : tmr_timer16

// *** sim/tmr_pins_model.sv ***
`timescale 1ns/100ps
module tmr_pins_model (
  input  wire logic clk_sys,
  output logic      edge_input_first,
  output logic      edge_input_second
);
  // the second line is pulled up, so it is high before the first start
  initial begin
    edge_input_first  = 1'b0;
    edge_input_second = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic level(input bit sel, input logic lvl);
    @(posedge clk_sys);
    if (sel) edge_input_second <= lvl;
    else edge_input_first <= lvl;
  endtask : level

  // callers never pick the first line as count clock while it triggers
  // trigger pulses are held above two count clocks, except the glitches and the 8-cycle pulses sent while stopped
  task automatic pulse(input bit sel, input int unsigned width);
    level(sel, 1'b1);
    repeat (width) @(posedge clk_sys);
    level(sel, 1'b0);
  endtask : pulse
endmodule : tmr_pins_model

// *** sim/tmr_timer16_tb.sv ***
`timescale 1ns/100ps
module tmr_timer16_tb;
  import tmr_pkg::*;
  typedef struct {
    logic [1:0]  src;
    logic        any;
    logic [15:0] exp;
  } tmr_note_s;
  logic             clk_sys         = 1'b0;
  logic             rst             = 1'b1;
  logic [1:0]       mode            = MODE_STOP;
  logic [1:0]       psel            = PSEL_DIV16;
  logic [CCR_W-1:0] ccr             = CCR_RESET;
  logic [1:0]       esf             = EDGE_NONE;
  logic [1:0]       ess             = EDGE_NONE;
  logic             cmp_first_wr    = 1'b0;
  logic [15:0]      cmp_first_wdata = 16'h0000;
  logic             overflow_clr    = 1'b0;
  logic             probe_q         = 1'b0;
  logic [1:0]       probe_src       = 2'h0;
  logic             pin1;
  logic             pin2;
  logic [15:0]      main_count;
  logic [15:0]      cap1;
  logic [15:0]      cap2;
  logic             overflow_flag;
  logic             irq1;
  logic             irq2;
  int               miscompares     = 0;
  int               num_checks      = 0;
  tmr_note_s        notes[$];
  string            nm[4] = '{"capture_first", "capture_second",
                              "overflow_flag", "main_count"};

  always #2 clk_sys = ~clk_sys;

  tmr_pins_model i_pins (.clk_sys(clk_sys), .edge_input_first(pin1),
                         .edge_input_second(pin2));

  tmr_timer16 i_dut (
    .clk_sys(clk_sys), .rst(rst),
    .op_mode_sel_high(mode[1]), .op_mode_sel_low(mode[0]),
    .prescaler_select(psel), .capture_control_reg(ccr),
    .edge_sel_first(esf), .edge_sel_second(ess),
    .edge_input_first(pin1), .edge_input_second(pin2),
    .cmp_first_wr(cmp_first_wr), .cmp_first_wdata(cmp_first_wdata),
    .cmp_second_wr(1'b0), .cmp_second_wdata(16'h0000),
    .overflow_clr(overflow_clr), .one_shot_en(1'b0), .one_shot_trig(1'b0),
    .main_count(main_count), .compare_capture_first(cap1),
    .compare_capture_second(cap2), .overflow_flag(overflow_flag),
    .irq_match_first(irq1), .irq_match_second(irq2), .one_shot_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic note(input logic [1:0] src, input logic any,
                      input logic [15:0] exp);
    notes.push_back('{src, any, exp});
  endtask : note

  task automatic take(input logic [1:0] src, input logic [15:0] seen);
    tmr_note_s n;
    num_checks++;
    if (notes.size() == 0) begin
      miscompares++;
      $display("CHECK FAILED %s expected nothing seen %h", nm[src], seen);
    end else begin
      n = notes.pop_front();
      if (n.src !== src || (!n.any && n.exp !== seen)) begin
        miscompares++;
        $display("CHECK FAILED %s expected %s %h seen %s %h", nm[src],
                 nm[n.src], n.exp, nm[src], seen);
      end
    end
  endtask : take

  task automatic probe(input logic [1:0] src, input logic [15:0] exp);
    note(src, 1'b0, exp);
    @(posedge clk_sys);
    probe_src <= src;
    probe_q   <= 1'b1;
    @(posedge clk_sys);
    probe_q   <= 1'b0;
  endtask : probe

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_sys);
    mode <= m;
  endtask : set_mode

  // returns at the first sample after the counter has stepped
  task automatic sync_step(output logic [15:0] n);
    logic [15:0] p;
    int          i;
    @(negedge clk_sys);
    p = main_count;
    for (i = 0; i < 40 && main_count === p; i++) @(negedge clk_sys);
    n = main_count;
  endtask : sync_step

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (!rst) begin
      if (irq1 === 1'b1) take(2'd0, cap1);
      if (irq2 === 1'b1) take(2'd1, cap2);
      if (probe_q) take(probe_src, (probe_src == 2'd2) ?
                        {15'h0000, overflow_flag} : main_count);
    end
  end

  initial begin
    #(320000);
    miscompares++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    logic [15:0] n;
    int          k;
    void'($urandom(32'ha1195c4b));
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    probe(2'd3, CNT_ZERO);
    probe(2'd2, 16'h0000);
    ccr <= 3'h5;
    ess <= EDGE_RISE;
    note(2'd0, 1'b1, 16'h0000);
    set_mode(MODE_FREE_RUN);
    cyc(120);
    set_mode(MODE_STOP);
    cyc(4);
    set_mode(MODE_FREE_RUN);
    cyc(120);
    set_mode(MODE_STOP);
    i_pins.pulse(1'b1, 8);
    i_pins.pulse(1'b0, 8);
    probe(2'd3, CNT_ZERO);
    ess <= EDGE_NONE;
    esf <= EDGE_RISE;
    set_mode(MODE_FREE_RUN);
    cyc(40);
    sync_step(n);
    i_pins.pulse(1'b0, 1 + $urandom_range(2));
    cyc(60);
    sync_step(n);
    note(2'd1, 1'b0, n + 16'h0002);
    i_pins.pulse(1'b0, 48);
    cyc(60);
    ccr <= 3'h3;
    sync_step(n);
    // falling edge of the first line loads the first register silently
    i_pins.pulse(1'b0, 48);
    cyc(60);
    ess <= EDGE_RISE;
    note(2'd0, 1'b0, n + 16'h0005);
    i_pins.pulse(1'b1, 48);
    cyc(60);
    set_mode(MODE_STOP);
    ccr <= 3'h4;
    psel <= PSEL_DIV1;
    @(posedge clk_sys);
    cmp_first_wr    <= 1'b1;
    cmp_first_wdata <= CNT_MAX;
    @(posedge clk_sys);
    cmp_first_wr    <= 1'b0;
    note(2'd0, 1'b0, CNT_MAX);
    set_mode(MODE_MATCH_CLEAR);
    k = 0;
    while (main_count !== CNT_MAX && k < 70000) begin
      @(negedge clk_sys);
      k++;
    end
    // this clear is sampled while the counter still reads 0000
    @(posedge clk_sys);
    overflow_clr <= 1'b1;
    @(posedge clk_sys);
    overflow_clr <= 1'b0;
    probe(2'd2, 16'h0001);
    @(posedge clk_sys);
    overflow_clr <= 1'b1;
    @(posedge clk_sys);
    overflow_clr <= 1'b0;
    probe(2'd2, 16'h0000);
    set_mode(MODE_STOP);
    cyc(4);
    num_checks++;
    if (notes.size() != 0) begin
      miscompares++;
      $display("CHECK FAILED notes expected 0 seen %0d", notes.size());
    end
    stop_test();
  end
endmodule : tmr_timer16_tb
